//--- design/flsq_sequencer.sv
// Operation
// - erased sector reads back as all ones
// - programming only clears bits, never sets
// - erase clears one whole sector, any index
// - read of corrupted pageword flags an error
// - sector erase lasts about 100 ms
// - full sector program lasts about 1 ms
// - addresses are byte offsets from flash start
// - equal 32 KB sectors, count per variant
// - enabled error interrupt follows array errors
// - reads start anywhere, run requested length
`timescale 1ns/1ps
module flsq_sequencer #(
    parameter int ERASE_CYCLES       = flsq_pkg::ERASE_CYCLES,
    parameter int SECTOR_PROG_CYCLES = flsq_pkg::SECTOR_PROG_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                reqValid,
    input  wire flsq_pkg::flsq_req_s req,
    output logic                     reqReady,
    output logic                     busy,
    output flsq_pkg::flsq_rd_s       rd,
    output logic                     errFlag,
    input  wire logic                errClr,
    input  wire logic                errIrqEn,
    output logic                     errIrq
);

    // ************************************************************
    // timing and state
    // ************************************************************
    // per-pageword share of the sector program time, rounded down
    localparam int PW_CYC_RAW   = SECTOR_PROG_CYCLES / flsq_pkg::PW_PER_SECTOR;
    localparam int PROG_PW_CYC  = (PW_CYC_RAW < 1) ? 1 : PW_CYC_RAW;
    localparam int ERASE_CYC    = (ERASE_CYCLES < flsq_pkg::PW_PER_SECTOR)
                                  ? flsq_pkg::PW_PER_SECTOR : ERASE_CYCLES;
    localparam logic [flsq_pkg::TIMER_W-1:0] ERASE_LOAD =
        flsq_pkg::TIMER_W'(ERASE_CYC - 1);
    localparam logic [flsq_pkg::TIMER_W-1:0] PROG_LOAD =
        flsq_pkg::TIMER_W'(PROG_PW_CYC - 1);
    localparam logic [flsq_pkg::PW_SEC_W-1:0] WIPE_LAST = {flsq_pkg::PW_SEC_W{1'b1}};

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ERASE,
        ST_PROG,
        ST_RD_FETCH,
        ST_RD_SEND
    } flsq_state_e;

    typedef struct packed {
        flsq_state_e                       st;
        logic [flsq_pkg::TIMER_W-1:0]      timer;
        logic [flsq_pkg::PW_SEC_W-1:0]     wipeIdx;
        logic                              wipeDone;
        logic                              first;
        logic [flsq_pkg::ADDR_W-1:0]       addr;
        logic [flsq_pkg::LEN_W-1:0]        len;
        logic [flsq_pkg::PW_W-1:0]         data;
        logic                              ready;
        logic                              busy;
        flsq_pkg::flsq_rd_s                rd;
        logic                              errFlag;
        logic                              errIrq;
    } flsq_seq_s;

    flsq_seq_s                    s_r;
    flsq_seq_s                    s_nxt;
    flsq_pkg::flsq_arr_s          arrCmd;
    logic [flsq_pkg::PW_W-1:0]    arrRdData;
    logic                         arrRdBad;

    // ************************************************************
    // array
    // ************************************************************
    flsq_array u_array (
        .clock  (clock),
        .arrCmd (arrCmd),
        .rdData (arrRdData),
        .rdBad  (arrRdBad)
    );

    // ************************************************************
    // sequencing
    // ************************************************************
    // next state and array command
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rd.valid = 1'b0;
        s_nxt.rd.last  = 1'b0;
        s_nxt.rd.err   = 1'b0;
        arrCmd.cmd     = flsq_pkg::ARR_IDLE;
        arrCmd.idx     = s_r.addr[flsq_pkg::ADDR_W-1:flsq_pkg::PW_OFS_W];
        arrCmd.data    = s_r.data;
        unique case (s_r.st)
            ST_IDLE: begin
                // addr is a byte offset into flash, no base applied
                if (reqValid && s_r.ready) begin
                    unique case (req.op)
                        flsq_pkg::OP_ERASE: begin
                            // whole sector: keep sector bits, clear the rest
                            s_nxt.addr     = {req.addr[flsq_pkg::ADDR_W-1 -: flsq_pkg::SEC_W],
                                              {(flsq_pkg::ADDR_W - flsq_pkg::SEC_W){1'b0}}};
                            s_nxt.timer    = ERASE_LOAD;
                            s_nxt.wipeIdx  = '0;
                            s_nxt.wipeDone = 1'b0;
                            s_nxt.st       = ST_ERASE;
                        end
                        flsq_pkg::OP_PROGRAM: begin
                            // low offset bits dropped: units are whole pagewords
                            s_nxt.addr  = {req.addr[flsq_pkg::ADDR_W-1:flsq_pkg::PW_OFS_W],
                                           {flsq_pkg::PW_OFS_W{1'b0}}};
                            s_nxt.data  = req.data;
                            s_nxt.timer = PROG_LOAD;
                            s_nxt.first = 1'b1;
                            s_nxt.st    = ST_PROG;
                        end
                        flsq_pkg::OP_READ: begin
                            // zero-length reads are taken and dropped
                            s_nxt.addr = req.addr;
                            s_nxt.len  = req.len;
                            if (req.len != '0) begin
                                s_nxt.st = ST_RD_FETCH;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_ERASE: begin
                // wipe one pageword per cycle inside the erase time
                if (!s_r.wipeDone) begin
                    arrCmd.cmd    = flsq_pkg::ARR_WIPE;
                    arrCmd.idx    = {s_r.addr[flsq_pkg::ADDR_W-1 -: flsq_pkg::SEC_W],
                                     s_r.wipeIdx};
                    s_nxt.wipeIdx = s_r.wipeIdx + 1'b1;
                    if (s_r.wipeIdx == WIPE_LAST) begin
                        s_nxt.wipeDone = 1'b1;
                    end
                end
                if (s_r.timer == '0) begin
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.timer = s_r.timer - 1'b1;
                end
            end
            ST_PROG: begin
                // a non-blank target is marked bad by the array, not refused
                if (s_r.first) begin
                    arrCmd.cmd  = flsq_pkg::ARR_PROG;
                    s_nxt.first = 1'b0;
                end
                if (s_r.timer == '0) begin
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.timer = s_r.timer - 1'b1;
                end
            end
            ST_RD_FETCH: begin
                arrCmd.cmd = flsq_pkg::ARR_READ;
                s_nxt.st   = ST_RD_SEND;
            end
            ST_RD_SEND: begin
                // two cycles per byte: simple, reads are not the hot path
                s_nxt.rd.valid = 1'b1;
                s_nxt.rd.data  = arrRdData[{s_r.addr[flsq_pkg::PW_OFS_W-1:0], 3'h0} +: 8];
                s_nxt.rd.err   = arrRdBad;
                s_nxt.rd.last  = (s_r.len == 16'h0001);
                s_nxt.addr     = s_r.addr + 1'b1;
                s_nxt.len      = s_r.len - 1'b1;
                s_nxt.st       = (s_r.len == 16'h0001) ? ST_IDLE : ST_RD_FETCH;
            end
        endcase

        // ********************************************************
        // error flag and interrupt
        // ********************************************************
        // set wins over a clear in the same cycle
        s_nxt.errFlag = (s_r.errFlag & ~errClr) | s_nxt.rd.err;
        s_nxt.errIrq  = s_nxt.errFlag & errIrqEn;

        // status
        s_nxt.ready = (s_nxt.st == ST_IDLE);
        s_nxt.busy  = (s_nxt.st == ST_ERASE) || (s_nxt.st == ST_PROG);
    end

    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reqReady = s_r.ready;
    assign busy     = s_r.busy;
    assign rd       = s_r.rd;
    assign errFlag  = s_r.errFlag;
    assign errIrq   = s_r.errIrq;

endmodule

//--- design/flsq_pkg.sv
package flsq_pkg;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int NUM_SECTORS   = 16;
    localparam int SECTOR_KB     = 32;
    localparam int SECTOR_BYTES  = SECTOR_KB * 1024;
    localparam int PW_BYTES      = 16;
    localparam int PW_W          = PW_BYTES * 8;
    localparam int PW_OFS_W      = $clog2(PW_BYTES);
    localparam int SEC_W         = $clog2(NUM_SECTORS);
    localparam int PW_PER_SECTOR = SECTOR_BYTES / PW_BYTES;
    localparam int PW_SEC_W      = $clog2(PW_PER_SECTOR);
    localparam int ADDR_W        = SEC_W + PW_SEC_W + PW_OFS_W;
    localparam int PW_IDX_W      = ADDR_W - PW_OFS_W;
    localparam int NUM_PW        = NUM_SECTORS * PW_PER_SECTOR;
    localparam int LEN_W         = 16;

    // erased pageword: every bit at one
    localparam logic [PW_W-1:0] BLANK_PW = {PW_W{1'b1}};

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ             = 200;
    localparam int ERASE_TIME_MS       = 100;
    localparam int SECTOR_PROG_TIME_US = 1000;
    localparam int ERASE_CYCLES        = ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int SECTOR_PROG_CYCLES  = SECTOR_PROG_TIME_US * CLK_MHZ;
    localparam int TIMER_W             = 25;

    // ************************************************************
    // request and answer carriers
    // ************************************************************
    typedef enum logic [1:0] {
        OP_READ,
        OP_PROGRAM,
        OP_ERASE
    } flsq_op_e;

    typedef struct packed {
        flsq_op_e          op;
        logic [ADDR_W-1:0] addr;   // byte offset from start of flash
        logic [LEN_W-1:0]  len;    // read length in bytes
        logic [PW_W-1:0]   data;   // one pageword for program
    } flsq_req_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       err;
        logic [7:0] data;
    } flsq_rd_s;

    typedef enum logic [1:0] {
        ARR_IDLE,
        ARR_READ,
        ARR_PROG,
        ARR_WIPE
    } flsq_arr_e;

    typedef struct packed {
        flsq_arr_e           cmd;
        logic [PW_IDX_W-1:0] idx;
        logic [PW_W-1:0]     data;
    } flsq_arr_s;

endpackage

//--- design/flsq_array.sv
`timescale 1ns/1ps
module flsq_array (
    input  wire logic                      clock,
    input  wire flsq_pkg::flsq_arr_s       arrCmd,
    output logic [flsq_pkg::PW_W-1:0]      rdData,
    output logic                           rdBad
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [flsq_pkg::PW_W-1:0] mem [0:flsq_pkg::NUM_PW-1];
    logic                      bad [0:flsq_pkg::NUM_PW-1];

    // parts leave the factory blank; contents survive reset
    initial begin
        for (int i = 0; i < flsq_pkg::NUM_PW; i++) begin
            mem[i] = flsq_pkg::BLANK_PW;
            bad[i] = 1'b0;
        end
    end

    // one pageword operation per cycle, read data one cycle later
    // plain clocked process: the storage is also preset by the initial block
    always @(posedge clock) begin
        unique case (arrCmd.cmd)
            flsq_pkg::ARR_READ: begin
                rdData <= mem[arrCmd.idx];
                rdBad  <= bad[arrCmd.idx];
            end
            flsq_pkg::ARR_PROG: begin
                mem[arrCmd.idx] <= mem[arrCmd.idx] & arrCmd.data;
                // overwriting a non-blank pageword corrupts its read-back
                bad[arrCmd.idx] <= bad[arrCmd.idx] | (mem[arrCmd.idx] != flsq_pkg::BLANK_PW);
            end
            flsq_pkg::ARR_WIPE: begin
                mem[arrCmd.idx] <= flsq_pkg::BLANK_PW;
                bad[arrCmd.idx] <= 1'b0;
            end
            flsq_pkg::ARR_IDLE: begin
            end
        endcase
    end

endmodule

//--- bench/flsq_sequencer_monitor.sv
`timescale 1ns/1ps
module flsq_sequencer_monitor #(
    parameter int ERASE_CYCLES       = 2048,
    parameter int SECTOR_PROG_CYCLES = 2048
) (
    input wire logic                clock,
    input wire logic                nrst,
    input wire logic                reqValid,
    input wire flsq_pkg::flsq_req_s req,
    input wire logic                reqReady,
    input wire logic                busy,
    input wire flsq_pkg::flsq_rd_s  rd,
    input wire logic                errFlag,
    input wire logic                errClr,
    input wire logic                errIrqEn,
    input wire logic                errIrq
);
    // ************************************************************
    // busy run length and kind of the last taken operation
    // ************************************************************
    localparam int ECYC = (ERASE_CYCLES < 2048) ? 2048 : ERASE_CYCLES;
    localparam int PCYC = (SECTOR_PROG_CYCLES < 2048) ? 1 : SECTOR_PROG_CYCLES / 2048;
    logic [31:0] runCnt_r;
    logic        wasErase_r;
    wire         takeReq = reqValid && reqReady;

    // counter rather than a repetition: erase runs thousands of cycles
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            runCnt_r   <= '0;
            wasErase_r <= 1'b0;
        end else begin
            runCnt_r <= busy ? runCnt_r + 32'h1 : 32'h0;
            if (takeReq) wasErase_r <= (req.op == flsq_pkg::OP_ERASE);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_take_busy; takeReq && req.op inside {flsq_pkg::OP_PROGRAM, flsq_pkg::OP_ERASE}
        |=> busy && !reqReady; endproperty
    a_take_busy: assert property (p_take_busy) else $error("no busy after write op");
    property p_busy_hold; busy |-> !reqReady; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("ready while busy");
    property p_erase_len; $fell(busy) && wasErase_r |-> runCnt_r == ECYC; endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
    property p_prog_len; $fell(busy) && !wasErase_r |-> runCnt_r == PCYC; endproperty
    a_prog_len: assert property (p_prog_len) else $error("program length wrong");
    property p_rd_first; takeReq && req.op == flsq_pkg::OP_READ && req.len != '0
        |-> ##3 rd.valid; endproperty
    a_rd_first: assert property (p_rd_first) else $error("first read byte late");
    property p_rd_pace; rd.valid && !rd.last |=> !rd.valid ##1 rd.valid; endproperty
    a_rd_pace: assert property (p_rd_pace) else $error("read byte pacing wrong");
    property p_err_set; rd.valid && rd.err |-> errFlag; endproperty
    a_err_set: assert property (p_err_set) else $error("error flag missed");
    property p_err_hold; errFlag && !errClr |=> errFlag; endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
    property p_irq; errIrq == (errFlag && $past(errIrqEn)); endproperty
    a_irq: assert property (p_irq) else $error("interrupt not gated flag");
endmodule

bind flsq_sequencer flsq_sequencer_monitor #(.ERASE_CYCLES(ERASE_CYCLES),
    .SECTOR_PROG_CYCLES(SECTOR_PROG_CYCLES)) i_flsq_sequencer_monitor (
    .clock(clock), .nrst(nrst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .busy(busy), .rd(rd), .errFlag(errFlag), .errClr(errClr), .errIrqEn(errIrqEn),
    .errIrq(errIrq));

//--- bench/flsq_host.sv
`timescale 1ns/1ps
module flsq_host (
    input  wire logic           clock,
    input  wire logic           reqReady,
    output logic                reqValid,
    output flsq_pkg::flsq_req_s req
);
    // ************************************************************
    // host side request driver
    // ************************************************************
    logic rdySeen = 1'b0;

    // idle bus at time zero
    initial begin
        reqValid = 1'b0;
        req      = '0;
    end

    // ready as the coming edge sees it, free of update races
    always @(negedge clock) rdySeen = reqReady;

    // no blank check here: one scenario overwrites a used pageword on purpose
    task automatic send(input flsq_pkg::flsq_op_e op, input logic [18:0] a,
                        input logic [15:0] n, input logic [127:0] d);
        @(posedge clock);
        reqValid <= 1'b1;
        req      <= '{op, (op == flsq_pkg::OP_PROGRAM) ? {a[18:4], 4'h0} : a, n, d};
        do @(posedge clock); while (rdySeen !== 1'b1);
        reqValid <= 1'b0;
        req      <= ~req;
    endtask
endmodule

//--- bench/tb_flsq_sequencer.sv
`timescale 1ns/1ps
module tb_flsq_sequencer;
    // ************************************************************
    // scenarios for the flash sequencer
    // ************************************************************
    localparam logic [127:0] PAT_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    localparam logic [127:0] PAT_B = 128'hF0F0_0FF0_AAAA_5555_C3C3_3C3C_FFFF_0000;
    logic                clock    = 1'b0;
    logic                nrst     = 1'b0;
    logic                errClr   = 1'b0;
    logic                errIrqEn = 1'b0;
    logic                reqValid, reqReady, busy, errFlag, errIrq;
    flsq_pkg::flsq_req_s req;
    flsq_pkg::flsq_rd_s  rd;
    logic [9:0]          rdQ[$];
    int                  err_count   = 0;
    int                  comparisons = 0;
    int                  busyCnt     = 0;

    // short erase keeps the run small; program busy drops to one cycle
    flsq_sequencer #(.ERASE_CYCLES(2048), .SECTOR_PROG_CYCLES(2048)) i_flsq_sequencer (
        .clock(clock), .nrst(nrst), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .busy(busy), .rd(rd), .errFlag(errFlag), .errClr(errClr), .errIrqEn(errIrqEn),
        .errIrq(errIrq));
    flsq_host i_flsq_host (.clock(clock), .reqReady(reqReady), .reqValid(reqValid), .req(req));

    // 200 MHz clock
    always #2.5 clock = ~clock;

    // outputs sampled mid-cycle, away from the launching edge
    always @(negedge clock) begin
        if (busy === 1'b1) busyCnt++;
        if (rd.valid === 1'b1) rdQ.push_back({rd.last, rd.err, rd.data});
    end

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] seen);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // read n bytes at a, all inside pageword pw; e is the expected error mark
    task automatic rd_chk(input logic [18:0] a, input int n, input logic [127:0] pw, input logic e);
        rdQ.delete();
        i_flsq_host.send(flsq_pkg::OP_READ, a, 16'(n), '0);
        repeat (2 * n + 3) @(posedge clock);
        @(negedge clock);
        check("rdCount", 128'(n), 128'(rdQ.size()));
        foreach (rdQ[k]) check("rdByte", {k == n-1, e, pw[8*((a+k)%16)+:8]}, rdQ[k]);
    endtask

    task automatic clr_err();
        @(posedge clock);
        errClr <= 1'b1;
        @(posedge clock);
        errClr <= 1'b0;
        @(negedge clock);
        check("errClear", 2'b00, {errFlag, errIrq});
    endtask

    task automatic t_blank();
        rd_chk(19'h7_8005, 6, flsq_pkg::BLANK_PW, 1'b0);
        // zero-length read is taken and must yield no byte
        rd_chk(19'h0_0003, 0, flsq_pkg::BLANK_PW, 1'b0);
    endtask

    task automatic t_prog();
        busyCnt = 0;
        i_flsq_host.send(flsq_pkg::OP_PROGRAM, 19'h1_8027, '0, PAT_A);
        repeat (3) @(negedge clock);
        check("progBusy", 128'd1, 128'(busyCnt));
        check("readyBack", 128'd1, 128'(reqReady));
        rd_chk(19'h1_8023, 12, PAT_A, 1'b0);
        @(posedge clock);
        errIrqEn <= 1'b1;
        i_flsq_host.send(flsq_pkg::OP_PROGRAM, 19'h1_8020, '0, PAT_B);
        rd_chk(19'h1_8020, 16, PAT_A & PAT_B, 1'b1);
        check("errSet", 2'b11, {errFlag, errIrq});
        clr_err();
        @(posedge clock);
        errIrqEn <= 1'b0;
        rd_chk(19'h1_802F, 1, PAT_A & PAT_B, 1'b1);
        check("errMasked", 2'b10, {errFlag, errIrq});
        clr_err();
    endtask

    // the program after the erase waits out the whole busy span
    task automatic t_erase();
        i_flsq_host.send(flsq_pkg::OP_PROGRAM, 19'h1_FFF0, '0, PAT_A);
        i_flsq_host.send(flsq_pkg::OP_PROGRAM, 19'h2_0000, '0, PAT_B);
        i_flsq_host.send(flsq_pkg::OP_ERASE, 19'h1_C00D, '0, '0);
        busyCnt = 0;
        i_flsq_host.send(flsq_pkg::OP_PROGRAM, 19'h1_8020, '0, PAT_B);
        check("eraseBusy", 128'd2048, 128'(busyCnt));
        rd_chk(19'h1_8020, 16, PAT_B, 1'b0);
        rd_chk(19'h1_FFF0, 16, flsq_pkg::BLANK_PW, 1'b0);
        rd_chk(19'h2_0000, 16, PAT_B, 1'b0);
    endtask

    task automatic close_out();
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // about nine times the expected run
    initial begin
        #100_000;
        err_count++;
        close_out();
    end

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_blank();
        t_prog();
        t_erase();
        close_out();
    end
endmodule
